// *** rtl/pmx_regs.svh ***
/*
 * Constants of the pin function multiplexer: pin numbering, field
 * codes and reset values of the function selects.
 * Assumes inclusion by pmx_pkg.sv before any design file.
 */
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// Flat pin index: port A 0..11, B 12..23, C 24..31, D 32..37
`define PMX_NPIN 38
`define PMX_PA_W 12
`define PMX_PB_W 12
`define PMX_PC_W 8
`define PMX_PD_W 6
`define PMX_PB_BASE 12
`define PMX_PC_BASE 24
`define PMX_PD_BASE 32
`define PMX_D5_PIN 37

// Number of routable functions, code 0 of the enum is GPIO
`define PMX_NFN 53
`define PMX_FN_W 6

// Per-pin select field: 2 bits, code 0 selects GPIO
`define PMX_CODE_W 2
`define PMX_CODE_GPIO 2'h0
`define PMX_CODE_F1 2'h1
`define PMX_CODE_F2 2'h2
`define PMX_CODE_F3 2'h3

// Reset selects: A7 as reset input, D0..D3 as test port, rest GPIO
`define PMX_SEL_RST 76'h55_0000_0000_0000_4000
`define PMX_D5_SEL_RST 2'h0

// Bonded pins; B4, B8 and B9 do not exist
`define PMX_USABLE 38'h3f_ffce_ffff

`endif

// *** rtl/pmx_pkg.sv ***
/*
 * Types of the pin function multiplexer: function enumeration,
 * select carrier and state record.
 * Assumes pmx_regs.svh is on the include path.
 */
`include "pmx_regs.svh"

package pmx_pkg;

	typedef enum logic [`PMX_FN_W-1:0] {
		pmx_gpio,
		pwm_channel_0_out, pwm_channel_1_out, pwm_channel_2_out,
		pwm_channel_3_out, pwm_channel_4_out, pwm_channel_5_out,
		timer_a_channel_0, timer_a_channel_1,
		timer_a_channel_2, timer_a_channel_3,
		fault_input_0, fault_input_1, fault_input_2, fault_input_3,
		comparator_a_input_1, comparator_b_input_1,
		comparator_a_input_2, comparator_b_input_2,
		comparator_a_input_3, comparator_b_input_3,
		comparator_a_output, comparator_b_output,
		pwm_source_input_0, pwm_source_input_1,
		reset_input,
		spi_sclk, spi_ss, spi_miso, spi_mosi,
		i2c_scl, i2c_sda,
		serial_receive_line, serial_transmit_line,
		external_clock_input,
		adc_a_input_0, adc_a_input_1, adc_a_input_2, adc_a_input_3,
		adc_b_input_0, adc_b_input_1, adc_b_input_2, adc_b_input_3,
		adc_a_reference_high, adc_a_reference_low,
		adc_b_reference_high, adc_b_reference_low,
		jtag_tdi, jtag_tdo, jtag_tck, jtag_tms,
		crystal_in, crystal_out
	} pmx_fn_t;

	typedef logic [`PMX_NPIN-1:0][`PMX_CODE_W-1:0] pmx_sel_t;

	typedef struct packed {
		pmx_sel_t sel;
		logic [`PMX_CODE_W-1:0] d5_sel;
		logic [`PMX_NPIN-1:0] pad_out;
		logic [`PMX_NPIN-1:0] pad_oe;
		logic [`PMX_NPIN-1:0] gpio_in;
		logic [`PMX_NFN-1:0] fn_in;
	} pmx_state_t;

endpackage

// *** rtl/pmx_pin_mux.sv ***
/*
 * Pin function multiplexer for four GPIO ports. Each pad is routed
 * to its GPIO port logic or to one on-chip peripheral function.
 * Assumes select inputs come from the system select registers and
 * that all pads and peripherals are synchronous to mclk_i.
 */
//
// Function
// RQ1: Ports A, B, C, D have 12/9/8/6 pins
// RQ2: Port A peripheral functions, A7 resets as reset
// RQ3: Port D: JTAG pins reset to JTAG
// RQ4: A4, A5 choose PWM, timer or fault
// RQ5: A6 chooses fault 0 or timer 0
// RQ6: A8 chooses fault 1, timer 2, comparator A
// RQ7: A9 chooses fault 2, timer 3, comparator B
// RQ8: B0 SCLK or SCL, B1 SS or SDA
// RQ9: B2 chooses MISO, timer 2, PWM source 0
// RQ10: B3 chooses MOSI, timer 3, PWM source 1
// RQ11: B5 chooses timer 1, fault 3, clock
// RQ12: B6 chooses receive, SDA, clock input
// RQ13: Clock input works only when PLL enables it
// RQ14: B7 chooses serial transmit or SCL
// RQ15: C0, C4 choose ADC or comparator input 3
// RQ16: C2, C3, C6, C7 choose ADC or reference
// RQ17: Selected peripheral owns pad, otherwise GPIO does
// RQ18: D5 chooses crystal or clock via own select
`timescale 1ns/100ps
`include "pmx_regs.svh"

module pmx_pin_mux (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [`PMX_PA_W-1:0] pa_in_i,
	output logic [`PMX_PA_W-1:0] pa_out_o,
	output logic [`PMX_PA_W-1:0] pa_oe_o,
	input wire logic [`PMX_PB_W-1:0] pb_in_i,
	output logic [`PMX_PB_W-1:0] pb_out_o,
	output logic [`PMX_PB_W-1:0] pb_oe_o,
	input wire logic [`PMX_PC_W-1:0] pc_in_i,
	output logic [`PMX_PC_W-1:0] pc_out_o,
	output logic [`PMX_PC_W-1:0] pc_oe_o,
	input wire logic [`PMX_PD_W-1:0] pd_in_i,
	output logic [`PMX_PD_W-1:0] pd_out_o,
	output logic [`PMX_PD_W-1:0] pd_oe_o,
	input wire pmx_pkg::pmx_sel_t pin_function_select_reg_i,
	input wire logic [`PMX_CODE_W-1:0] port_d_function_select_reg_i,
	input wire logic pll_external_clock_input_en_i,
	input wire logic [`PMX_NPIN-1:0] gpio_out_i,
	input wire logic [`PMX_NPIN-1:0] gpio_oe_i,
	output logic [`PMX_NPIN-1:0] gpio_in_o,
	input wire logic [`PMX_NFN-1:0] fn_out_i,
	input wire logic [`PMX_NFN-1:0] fn_oe_i,
	output logic [`PMX_NFN-1:0] fn_in_o
);

	pmx_pkg::pmx_state_t st_r;
	pmx_pkg::pmx_state_t st_nxt;
	pmx_pkg::pmx_fn_t fn_w [`PMX_NPIN];
	logic [`PMX_NPIN-1:0] pad_in;
	logic [`PMX_NPIN-1:0] usable;

	assign pad_in = {pd_in_i, pc_in_i, pb_in_i, pa_in_i};
	assign usable = `PMX_USABLE;

	function automatic pmx_pkg::pmx_fn_t pick(
		input logic [`PMX_CODE_W-1:0] c,
		input pmx_pkg::pmx_fn_t f1,
		input pmx_pkg::pmx_fn_t f2,
		input pmx_pkg::pmx_fn_t f3
	);
		pmx_pkg::pmx_fn_t f;
		unique case (c)
			`PMX_CODE_F1: f = f1;
			`PMX_CODE_F2: f = f2;
			`PMX_CODE_F3: f = f3;
			default: f = pmx_pkg::pmx_gpio;
		endcase
		return f;
	endfunction

	// Codes with no function behind them fall back to GPIO
	function automatic pmx_pkg::pmx_fn_t fn_of(
		input int pin,
		input logic [`PMX_CODE_W-1:0] c
	);
		pmx_pkg::pmx_fn_t g;
		pmx_pkg::pmx_fn_t f;
		g = pmx_pkg::pmx_gpio;
		case (pin)
			0: f = pick(c, pmx_pkg::pwm_channel_0_out, g, g); // [RQ2]
			1: f = pick(c, pmx_pkg::pwm_channel_1_out, g, g); // [RQ2]
			2: f = pick(c, pmx_pkg::pwm_channel_2_out, g, g); // [RQ2]
			3: f = pick(c, pmx_pkg::pwm_channel_3_out, g, g); // [RQ2]
			4: f = pick(c, pmx_pkg::pwm_channel_4_out,
				pmx_pkg::timer_a_channel_2, pmx_pkg::fault_input_1); // [RQ4]
			5: f = pick(c, pmx_pkg::pwm_channel_5_out,
				pmx_pkg::timer_a_channel_3, pmx_pkg::fault_input_2); // [RQ4]
			6: f = pick(c, pmx_pkg::fault_input_0,
				pmx_pkg::timer_a_channel_0, g); // [RQ5]
			7: f = pick(c, pmx_pkg::reset_input, g, g); // [RQ2]
			8: f = pick(c, pmx_pkg::fault_input_1,
				pmx_pkg::timer_a_channel_2,
				pmx_pkg::comparator_a_input_1); // [RQ6]
			9: f = pick(c, pmx_pkg::fault_input_2,
				pmx_pkg::timer_a_channel_3,
				pmx_pkg::comparator_b_input_1); // [RQ7]
			10: f = pick(c, pmx_pkg::comparator_a_input_2, g, g);
			11: f = pick(c, pmx_pkg::comparator_b_input_2, g, g);
			12: f = pick(c, pmx_pkg::spi_sclk, pmx_pkg::i2c_scl, g); // [RQ8]
			13: f = pick(c, pmx_pkg::spi_ss, pmx_pkg::i2c_sda, g); // [RQ8]
			14: f = pick(c, pmx_pkg::spi_miso, pmx_pkg::timer_a_channel_2,
				pmx_pkg::pwm_source_input_0); // [RQ9]
			15: f = pick(c, pmx_pkg::spi_mosi, pmx_pkg::timer_a_channel_3,
				pmx_pkg::pwm_source_input_1); // [RQ10]
			17: f = pick(c, pmx_pkg::timer_a_channel_1,
				pmx_pkg::fault_input_3,
				pmx_pkg::external_clock_input); // [RQ11]
			18: f = pick(c, pmx_pkg::serial_receive_line, pmx_pkg::i2c_sda,
				pmx_pkg::external_clock_input); // [RQ12]
			19: f = pick(c, pmx_pkg::serial_transmit_line,
				pmx_pkg::i2c_scl, g); // [RQ14]
			22: f = pick(c, pmx_pkg::comparator_a_output, g, g);
			23: f = pick(c, pmx_pkg::comparator_b_output, g, g);
			24: f = pick(c, pmx_pkg::adc_a_input_0,
				pmx_pkg::comparator_a_input_3, g); // [RQ15]
			25: f = pick(c, pmx_pkg::adc_a_input_1, g, g);
			26: f = pick(c, pmx_pkg::adc_a_input_2,
				pmx_pkg::adc_a_reference_high, g); // [RQ16]
			27: f = pick(c, pmx_pkg::adc_a_input_3,
				pmx_pkg::adc_a_reference_low, g); // [RQ16]
			28: f = pick(c, pmx_pkg::adc_b_input_0,
				pmx_pkg::comparator_b_input_3, g); // [RQ15]
			29: f = pick(c, pmx_pkg::adc_b_input_1, g, g);
			30: f = pick(c, pmx_pkg::adc_b_input_2,
				pmx_pkg::adc_b_reference_high, g); // [RQ16]
			31: f = pick(c, pmx_pkg::adc_b_input_3,
				pmx_pkg::adc_b_reference_low, g); // [RQ16]
			32: f = pick(c, pmx_pkg::jtag_tdi, g, g); // [RQ3]
			33: f = pick(c, pmx_pkg::jtag_tdo, g, g); // [RQ3]
			34: f = pick(c, pmx_pkg::jtag_tck, g, g); // [RQ3]
			35: f = pick(c, pmx_pkg::jtag_tms, g, g); // [RQ3]
			36: f = pick(c, pmx_pkg::crystal_in, g, g); // [RQ3]
			37: f = pick(c, pmx_pkg::crystal_out,
				pmx_pkg::external_clock_input, g); // [RQ18]
			default: f = g; // [RQ1]
		endcase
		return f;
	endfunction

	// Pin D5 has its own select register
	for (genvar p = 0; p < `PMX_NPIN; p++) begin : g_pin
		if (p == `PMX_D5_PIN) begin : g_d5
			assign fn_w[p] = fn_of(p, st_r.d5_sel); // [RQ18]
		end else begin : g_std
			assign fn_w[p] = fn_of(p, st_r.sel[p]);
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.sel = pin_function_select_reg_i;
		st_nxt.d5_sel = port_d_function_select_reg_i;
		st_nxt.gpio_in = pad_in;
		st_nxt.fn_in = '0;
		for (int p = 0; p < `PMX_NPIN; p++) begin
			if (fn_w[p] == pmx_pkg::pmx_gpio) begin
				st_nxt.pad_out[p] = gpio_out_i[p]; // [RQ17]
				st_nxt.pad_oe[p] = gpio_oe_i[p]; // [RQ17]
			end else begin
				st_nxt.pad_out[p] = fn_out_i[fn_w[p]]; // [RQ17]
				st_nxt.pad_oe[p] = fn_oe_i[fn_w[p]]; // [RQ17]
				st_nxt.fn_in[fn_w[p]] = st_nxt.fn_in[fn_w[p]] | pad_in[p];
			end
			// Missing bond sites never drive
			if (!usable[p]) begin
				st_nxt.pad_out[p] = 1'b0; // [RQ1]
				st_nxt.pad_oe[p] = 1'b0; // [RQ1]
			end
		end
		// Pin choice alone is not enough to feed the clock generator
		if (!pll_external_clock_input_en_i) begin
			st_nxt.fn_in[pmx_pkg::external_clock_input] = 1'b0; // [RQ13]
		end
		st_nxt.fn_in[pmx_pkg::pmx_gpio] = 1'b0;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
			st_r.sel <= `PMX_SEL_RST; // [RQ2] [RQ3]
			st_r.d5_sel <= `PMX_D5_SEL_RST; // [RQ18]
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pa_out_o = st_r.pad_out[`PMX_PB_BASE-1:0];
	assign pa_oe_o = st_r.pad_oe[`PMX_PB_BASE-1:0];
	assign pb_out_o = st_r.pad_out[`PMX_PC_BASE-1:`PMX_PB_BASE];
	assign pb_oe_o = st_r.pad_oe[`PMX_PC_BASE-1:`PMX_PB_BASE];
	assign pc_out_o = st_r.pad_out[`PMX_PD_BASE-1:`PMX_PC_BASE];
	assign pc_oe_o = st_r.pad_oe[`PMX_PD_BASE-1:`PMX_PC_BASE];
	assign pd_out_o = st_r.pad_out[`PMX_NPIN-1:`PMX_PD_BASE];
	assign pd_oe_o = st_r.pad_oe[`PMX_NPIN-1:`PMX_PD_BASE];
	assign gpio_in_o = st_r.gpio_in;
	assign fn_in_o = st_r.fn_in;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	property p_unbonded_quiet;
		##1 (pb_oe_o[4] | pb_oe_o[8] | pb_oe_o[9]) == 1'b0;
	endproperty
	a_unbonded_quiet: assert property (p_unbonded_quiet) // [RQ1]
		else $error("unbonded port B pin driven");

	property p_a4_pwm;
		st_r.sel[4] == `PMX_CODE_F1 && $stable(st_r.sel[4])
			|=> pa_out_o[4] == $past(fn_out_i[pmx_pkg::pwm_channel_4_out]);
	endproperty
	a_a4_pwm: assert property (p_a4_pwm) // [RQ4]
		else $error("A4 does not follow PWM 4");

	property p_a6_timer_in;
		st_r.sel[6] == `PMX_CODE_F2 && pa_in_i[6]
			|=> fn_in_o[pmx_pkg::timer_a_channel_0];
	endproperty
	a_a6_timer_in: assert property (p_a6_timer_in) // [RQ5]
		else $error("A6 input missing on timer channel 0");

	property p_a8_cmp;
		st_r.sel[8] == `PMX_CODE_F3 && pa_in_i[8]
			|=> fn_in_o[pmx_pkg::comparator_a_input_1];
	endproperty
	a_a8_cmp: assert property (p_a8_cmp) // [RQ6]
		else $error("A8 input missing on comparator A");

	property p_b0_scl_oe;
		st_r.sel[12] == `PMX_CODE_F2
			|=> pb_oe_o[0] == $past(fn_oe_i[pmx_pkg::i2c_scl]);
	endproperty
	a_b0_scl_oe: assert property (p_b0_scl_oe) // [RQ8]
		else $error("B0 enable does not follow SCL");

	property p_external_clock_input_gate;
		!pll_external_clock_input_en_i |=> !fn_in_o[pmx_pkg::external_clock_input];
	endproperty
	a_external_clock_input_gate: assert property (p_external_clock_input_gate) // [RQ13]
		else $error("clock input passed while PLL disables it");

	property p_c1_gpio;
		st_r.sel[25] == `PMX_CODE_GPIO
			|=> pc_out_o[1] == $past(gpio_out_i[25])
			&& pc_oe_o[1] == $past(gpio_oe_i[25]);
	endproperty
	a_c1_gpio: assert property (p_c1_gpio) // [RQ17]
		else $error("C1 not under GPIO control");

	property p_d0_jtag;
		st_r.sel[32] == `PMX_CODE_F1
			|=> pd_oe_o[0] == $past(fn_oe_i[pmx_pkg::jtag_tdi]);
	endproperty
	a_d0_jtag: assert property (p_d0_jtag) // [RQ3]
		else $error("D0 enable does not follow the test port");

	property p_d5_xtal;
		st_r.d5_sel == `PMX_CODE_F1
			|=> pd_out_o[5] == $past(fn_out_i[pmx_pkg::crystal_out]);
	endproperty
	a_d5_xtal: assert property (p_d5_xtal) // [RQ18]
		else $error("D5 does not follow crystal output");

	property p_sel_lag;
		1'b1 |=> st_r.sel == $past(pin_function_select_reg_i);
	endproperty
	a_sel_lag: assert property (p_sel_lag) // [RQ17]
		else $error("select not taken one cycle later");

	c_b6_rx: cover property (st_r.sel[18] == `PMX_CODE_F1 && pb_in_i[6]);
	c_external_clock_input_on: cover property (fn_in_o[pmx_pkg::external_clock_input]);
	c_c2_ref: cover property (st_r.sel[26] == `PMX_CODE_F2);

endmodule

// *** dv/pmx_periph_model.sv ***
/*
 * Behavioural stand-in for the peripherals and GPIO port logic that
 * sit behind the pin multiplexer: fresh random drive every cycle.
 * Assumes the bench seeds the generator and samples at falling edges.
 */
`timescale 1ns/100ps
`include "pmx_regs.svh"

module pmx_periph_model (
	input wire logic mclk_i,
	output logic [`PMX_NFN-1:0] fn_out_o = '0,
	output logic [`PMX_NFN-1:0] fn_oe_o = '0,
	output logic [`PMX_NPIN-1:0] gpio_out_o = '0,
	output logic [`PMX_NPIN-1:0] gpio_oe_o = '0
);
	// New values each cycle, so a stale route cannot match by luck
	always @(posedge mclk_i) begin
		#2;
		fn_out_o = `PMX_NFN'({$urandom(), $urandom()});
		fn_oe_o = `PMX_NFN'({$urandom(), $urandom()});
		gpio_out_o = `PMX_NPIN'({$urandom(), $urandom()});
		gpio_oe_o = `PMX_NPIN'({$urandom(), $urandom()});
	end
endmodule

// *** dv/tb.sv ***
/*
 * Self-checking bench of the pin multiplexer: walks every select
 * code of each shared pin and checks routing one edge later.
 * Assumes pmx_pkg and pmx_pin_mux are compiled before it.
 */
`timescale 1ns/100ps
`include "pmx_regs.svh"

module tb;
	typedef struct packed {
		int p;
		int f;
		logic o;
		logic e;
		logic fi;
	} pmx_exp_t;
	localparam pmx_pkg::pmx_fn_t gp = pmx_pkg::pmx_gpio;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [`PMX_NPIN-1:0] pad_in = '0;
	pmx_pkg::pmx_sel_t sel = '0;
	logic [1:0] dsel = 2'h0;
	logic pll = 1'b0;
	wire [`PMX_NPIN-1:0] gout, goe, gin, pout, poe;
	wire [`PMX_NFN-1:0] fout, foe, fin;
	pmx_exp_t q[$];
	pmx_exp_t mx;
	int num_errors = 0;
	int check_count = 0;

	always #5 mclk_i = ~mclk_i;

	pmx_periph_model u_far (.mclk_i(mclk_i), .fn_out_o(fout),
		.fn_oe_o(foe), .gpio_out_o(gout), .gpio_oe_o(goe));

	pmx_pin_mux u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.pa_in_i(pad_in[11:0]), .pa_out_o(pout[11:0]),
		.pa_oe_o(poe[11:0]), .pb_in_i(pad_in[23:12]),
		.pb_out_o(pout[23:12]), .pb_oe_o(poe[23:12]),
		.pc_in_i(pad_in[31:24]), .pc_out_o(pout[31:24]),
		.pc_oe_o(poe[31:24]), .pd_in_i(pad_in[37:32]),
		.pd_out_o(pout[37:32]), .pd_oe_o(poe[37:32]),
		.pin_function_select_reg_i(sel),
		.port_d_function_select_reg_i(dsel), .pll_external_clock_input_en_i(pll),
		.gpio_out_i(gout), .gpio_oe_i(goe), .gpio_in_o(gin),
		.fn_out_i(fout), .fn_oe_i(foe), .fn_in_o(fin));

	task automatic check(input logic seen, input logic exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic void step(int p, pmx_pkg::pmx_fn_t f, bit act);
		pmx_exp_t x;
		x.p = p;
		x.f = f;
		x.o = act ? fout[f] : gout[p];
		x.e = act ? foe[f] : goe[p];
		x.fi = act & pad_in[p] & (f != pmx_pkg::external_clock_input || pll);
		q.push_back(x);
	endfunction

	function automatic void rnd();
		pad_in = `PMX_NPIN'({$urandom(), $urandom()});
		pll = 1'($urandom());
	endfunction

	task automatic drive();
		@(negedge mclk_i);
		rnd();
	endtask

	// Old select still acts at the capture edge, new one an edge later
	task automatic chk_pin(int p, pmx_pkg::pmx_fn_t f1, f2, f3);
		pmx_pkg::pmx_fn_t fs[4];
		pmx_pkg::pmx_fn_t pf;
		fs = '{gp, f1, f2, f3};
		pf = gp;
		for (int c = 0; c < 5; c++) begin
			drive();
			if (p == `PMX_D5_PIN) dsel = 2'(c % 4);
			else sel[p] = 2'(c % 4);
			step(p, pf, pf != gp);
			pf = fs[c % 4];
			repeat (3) begin
				drive();
				step(p, pf, pf != gp);
			end
		end
	endtask

	always @(posedge mclk_i) begin
		#1;
		while (q.size() > 0) begin
			mx = q.pop_front();
			check(pout[mx.p], mx.o);
			check(poe[mx.p], mx.e);
			check(fin[mx.f], mx.fi);
			check(gin[mx.p], pad_in[mx.p]);
			check(|{poe[21:20], poe[16]}, 1'b0);
		end
	end

	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(26));
		repeat (3) @(negedge mclk_i);
		check(|{pout, poe, fin}, 1'b0);
		rstn_i = 1'b1;
		rnd();
		step(7, pmx_pkg::reset_input, 1);
		step(4, pmx_pkg::pwm_channel_4_out, 0);
		step(32, pmx_pkg::jtag_tdi, 1);
		step(33, pmx_pkg::jtag_tdo, 1);
		step(34, pmx_pkg::jtag_tck, 1);
		step(35, pmx_pkg::jtag_tms, 1);
		step(36, pmx_pkg::crystal_in, 0);
		step(37, pmx_pkg::crystal_out, 0);
		drive();
		step(7, pmx_pkg::reset_input, 0);
		step(35, pmx_pkg::jtag_tms, 0);
		sel = `PMX_SEL_RST;
		sel[37] = 2'h3;
		drive();
		step(7, pmx_pkg::reset_input, 1);
		chk_pin(4, pmx_pkg::pwm_channel_4_out, pmx_pkg::timer_a_channel_2,
			pmx_pkg::fault_input_1);
		chk_pin(5, pmx_pkg::pwm_channel_5_out, pmx_pkg::timer_a_channel_3,
			pmx_pkg::fault_input_2);
		chk_pin(6, pmx_pkg::fault_input_0, pmx_pkg::timer_a_channel_0,
			gp);
		chk_pin(8, pmx_pkg::fault_input_1, pmx_pkg::timer_a_channel_2,
			pmx_pkg::comparator_a_input_1);
		chk_pin(9, pmx_pkg::fault_input_2, pmx_pkg::timer_a_channel_3,
			pmx_pkg::comparator_b_input_1);
		chk_pin(12, pmx_pkg::spi_sclk, pmx_pkg::i2c_scl, gp);
		chk_pin(13, pmx_pkg::spi_ss, pmx_pkg::i2c_sda, gp);
		chk_pin(14, pmx_pkg::spi_miso, pmx_pkg::timer_a_channel_2,
			pmx_pkg::pwm_source_input_0);
		chk_pin(15, pmx_pkg::spi_mosi, pmx_pkg::timer_a_channel_3,
			pmx_pkg::pwm_source_input_1);
		chk_pin(17, pmx_pkg::timer_a_channel_1, pmx_pkg::fault_input_3,
			pmx_pkg::external_clock_input);
		chk_pin(18, pmx_pkg::serial_receive_line, pmx_pkg::i2c_sda,
			pmx_pkg::external_clock_input);
		chk_pin(19, pmx_pkg::serial_transmit_line, pmx_pkg::i2c_scl,
			gp);
		chk_pin(24, pmx_pkg::adc_a_input_0, pmx_pkg::comparator_a_input_3,
			gp);
		chk_pin(28, pmx_pkg::adc_b_input_0, pmx_pkg::comparator_b_input_3,
			gp);
		chk_pin(26, pmx_pkg::adc_a_input_2, pmx_pkg::adc_a_reference_high,
			gp);
		chk_pin(27, pmx_pkg::adc_a_input_3, pmx_pkg::adc_a_reference_low,
			gp);
		chk_pin(30, pmx_pkg::adc_b_input_2, pmx_pkg::adc_b_reference_high,
			gp);
		chk_pin(31, pmx_pkg::adc_b_input_3, pmx_pkg::adc_b_reference_low,
			gp);
		chk_pin(37, pmx_pkg::crystal_out, pmx_pkg::external_clock_input,
			gp);
		repeat (2) drive();
		give_verdict();
	end
endmodule
